// ### clss_defs.vh
`ifndef CLSS_DEFS_VH
`define CLSS_DEFS_VH
// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define CLSS_OFF_CTRL      8'h00
`define CLSS_OFF_VEL       8'h04
`define CLSS_OFF_ACCEL     8'h08
`define CLSS_OFF_MAXW      8'h0C
`define CLSS_OFF_LIMIT     8'h10
`define CLSS_OFF_LRTIME    8'h14
`define CLSS_OFF_IRQSEL    8'h18
`define CLSS_OFF_STATUS    8'h1C
`define CLSS_OFF_POSERR    8'h20
`define CLSS_OFF_MISSED    8'h24
`define CLSS_OFF_MKTIME    8'h28
`define CLSS_OFF_ERRCODE   8'h2C
// ****************************************************************
// Control register fields.
// ****************************************************************
`define CLSS_CTRL_TRACK    0
`define CLSS_CTRL_VMODE    1
`define CLSS_CTRL_TMODE    2
`define CLSS_CTRL_MAKEUP   3
`define CLSS_CTRL_CAL      4
`define CLSS_CTRL_CLRPOS   5
// ****************************************************************
// Status bits, also the interrupt select positions.
// ****************************************************************
`define CLSS_ST_TRACK      0
`define CLSS_ST_MAKEUP     1
`define CLSS_ST_LIMIT      2
`define CLSS_ST_LOCKED     3
`define CLSS_ST_CAL        4
`define CLSS_ST_OVF        5
`define CLSS_NUM_ST        6
// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define CLSS_CTRL_RST      6'h01
`define CLSS_MAXW_RST      16'h0032
`define CLSS_CAL_CYCLES    16'h0400
`define CLSS_FULL_STEP     16'h0100
`define CLSS_ERR_NONE      8'h00
`define CLSS_ERR_LIMIT     8'h01
`define CLSS_ERR_LOCKED    8'h02
`define CLSS_ERR_OVF       8'h03
`endif

// ### clss_far_end.sv
`timescale 1ns/10ps
// ****************************************************************
// Host step pin shaper and quadrature encoder on the motor shaft.
// ****************************************************************
module clss_far_end (
    input  wire i_ref_clk,
    input  wire i_rst_b,
    input  wire i_req,
    input  wire i_follow,
    input  wire i_mstep,
    input  wire i_mdir,
    output wire o_step_pin,
    output wire o_enc_a,
    output wire o_enc_b
);
    reg [1:0] hold_reg;
    reg [1:0] phase_reg;
    // A request holds the step pin high three cycles, long enough for the pin synchroniser.
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_reg  <= 2'h0;
            phase_reg <= 2'h0;
        end else begin
            hold_reg <= i_req ? 2'h3 : (hold_reg != 2'h0 ? hold_reg - 2'h1 : 2'h0);
            // The rotor follows each stator step unless the bench stalls it.
            if (i_mstep && i_follow) begin
                phase_reg <= i_mdir ? phase_reg + 2'h1 : phase_reg - 2'h1;
            end
        end
    end
    // Counting up makes channel A lead channel B, the positive direction.
    assign o_step_pin = (hold_reg != 2'h0);
    assign o_enc_a = phase_reg[1] ^ phase_reg[0];
    assign o_enc_b = phase_reg[1];
endmodule // clss_far_end

// ### clss_supervisor.v
// Behaviour
// - One interrupt output, OR of all selected status conditions.
// - Status and error code readable to identify the interrupt cause.
// - Tracking-active condition while loop intervenes; selectable interrupt source.
// - Make-up-active condition while correction steps inserted; selectable source.
// - Velocity mode: start/stop begins and ends internal steps at programmed velocity.
// - Velocity steps ramp by programmed acceleration, capped by maximum frequency.
// - Torque mode: start/stop begins and ends programmed torque.
// - Torque mode advances stator to hold one full step lead; the code keeps stepping at the rate reached once the lead passes a full step.
// - Torque mode raises stepping rate while shift below one full step.
// - Torque stepping rate capped by maximum system speed.
// - Torque mode inserts no make-up steps but updates position error.
// - Tracking disabled: incoming step passes straight to step output.
// - In bypass lag/lead calculations are inactive and held at zero.
// - Switching free; enabling tracking runs automatic calibration.
// - Counters of missed steps and time spent in make-up.
// - Flag when position error reaches lag or lead limit; interrupt source.
// - Locked-rotor flag when timer started at maximum lag reaches zero.
// - During calibration lag/lead cleared and incoming steps ignored.
`timescale 1ns/10ps
`include "clss_defs.vh"
module clss_supervisor #(
    parameter LRT_W = 24
) (
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    input  wire        i_hsel,
    input  wire [31:0] i_haddr,
    input  wire [1:0]  i_htrans,
    input  wire        i_hwrite,
    input  wire [2:0]  i_hsize,
    input  wire [31:0] i_hwdata,
    input  wire        i_hready,
    output reg  [31:0] o_hrdata,
    output reg         o_hreadyout,
    output reg         o_hresp,
    input  wire        i_step,
    input  wire        i_dir,
    input  wire        i_start,
    input  wire        i_enc_a,
    input  wire        i_enc_b,
    output reg         o_step,
    output reg         o_dir,
    output reg         o_torque_en,
    output reg  [15:0] o_torque,
    output reg         o_irq
);
// ****************************************************************
// Input synchronisers.
// ****************************************************************
reg [1:0] s1_reg;
reg [1:0] s2_reg;
reg [1:0] a_reg;
reg [1:0] b_reg;
reg [1:0] st_reg;
reg       step_d_reg;
reg       enc_a_d_reg;
reg       enc_b_d_reg;
// Two flip-flops on every pin; the step and encoder pins add a third stage for edge detection.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        s1_reg      <= 2'h0;
        s2_reg      <= 2'h0;
        a_reg       <= 2'h0;
        b_reg       <= 2'h0;
        st_reg      <= 2'h0;
        step_d_reg  <= 1'b0;
        enc_a_d_reg <= 1'b0;
        enc_b_d_reg <= 1'b0;
    end else begin
        s1_reg      <= {s1_reg[0], i_step};
        s2_reg      <= {s2_reg[0], i_dir};
        a_reg       <= {a_reg[0], i_enc_a};
        b_reg       <= {b_reg[0], i_enc_b};
        st_reg      <= {st_reg[0], i_start};
        step_d_reg  <= s1_reg[1];
        enc_a_d_reg <= a_reg[1];
        enc_b_d_reg <= b_reg[1];
    end
end
wire step_in  = s1_reg[1];
wire dir_in   = s2_reg[1];
wire start_in = st_reg[1];
wire step_rise = s1_reg[1] & ~step_d_reg;
// Any encoder edge counts as movement for calibration and the locked-rotor timer.
wire enc_move  = (a_reg[1] ^ enc_a_d_reg) | (b_reg[1] ^ enc_b_d_reg);
// Quadrature direction: A leading B counts up.
wire enc_up    = a_reg[1] ^ enc_b_d_reg;
// ****************************************************************
// Register file and AHB-Lite slave.
// ****************************************************************
reg [5:0]  ctrl_reg;
reg [15:0] vel_reg;
reg [15:0] accel_reg;
reg [15:0] maxw_reg;
reg [15:0] limit_reg;
reg [LRT_W-1:0] lrtime_reg;
reg [5:0]  irqsel_reg;
reg [7:0]  errcode_reg;
reg        wr_pend_reg;
reg [7:0]  wr_addr_reg;
reg        cal_req_reg;
reg        clr_pos_reg;
reg [31:0] poserr_reg;
reg [31:0] missed_reg;
reg [31:0] mktime_reg;
reg [5:0]  status_reg;
// Only a NONSEQ or SEQ transfer with ready high opens an access.
wire addr_ph = i_hsel & i_hready & i_htrans[1];
wire [31:0] wd = i_hwdata;
// Write data lands in the data phase; reads answer with zero wait.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        ctrl_reg    <= `CLSS_CTRL_RST;
        vel_reg     <= 16'h0000;
        accel_reg   <= 16'h0000;
        maxw_reg    <= `CLSS_MAXW_RST;
        limit_reg   <= 16'hFFFF;
        lrtime_reg  <= {LRT_W{1'b1}};
        irqsel_reg  <= 6'h00;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        cal_req_reg <= 1'b0;
        clr_pos_reg <= 1'b0;
        o_hrdata    <= 32'h00000000;
        o_hreadyout <= 1'b1;
        o_hresp     <= 1'b0;
    end else begin
        cal_req_reg <= 1'b0;
        clr_pos_reg <= 1'b0;
        wr_pend_reg <= addr_ph & i_hwrite;
        wr_addr_reg <= i_haddr[7:0];
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `CLSS_OFF_CTRL: begin
                    ctrl_reg <= {1'b0, 1'b0, wd[3:0]};
                    // Enabling tracking starts an automatic calibration.
                    cal_req_reg <= wd[`CLSS_CTRL_CAL] |
                                   (wd[`CLSS_CTRL_TRACK] & ~ctrl_reg[`CLSS_CTRL_TRACK]);
                    clr_pos_reg <= wd[`CLSS_CTRL_CLRPOS];
                end
                `CLSS_OFF_VEL:    vel_reg    <= wd[15:0];
                `CLSS_OFF_ACCEL:  accel_reg  <= wd[15:0];
                `CLSS_OFF_MAXW:   maxw_reg   <= wd[15:0];
                `CLSS_OFF_LIMIT:  limit_reg  <= wd[15:0];
                `CLSS_OFF_LRTIME: lrtime_reg <= wd[LRT_W-1:0];
                `CLSS_OFF_IRQSEL: irqsel_reg <= wd[5:0];
                default: ;
            endcase
        end
        if (addr_ph && !i_hwrite) begin
            case (i_haddr[7:0])
                `CLSS_OFF_CTRL:    o_hrdata <= {26'h0, ctrl_reg};
                `CLSS_OFF_VEL:     o_hrdata <= {16'h0, vel_reg};
                `CLSS_OFF_ACCEL:   o_hrdata <= {16'h0, accel_reg};
                `CLSS_OFF_MAXW:    o_hrdata <= {16'h0, maxw_reg};
                `CLSS_OFF_LIMIT:   o_hrdata <= {16'h0, limit_reg};
                `CLSS_OFF_LRTIME:  o_hrdata <= {{(32-LRT_W){1'b0}}, lrtime_reg};
                `CLSS_OFF_IRQSEL:  o_hrdata <= {26'h0, irqsel_reg};
                `CLSS_OFF_STATUS:  o_hrdata <= {26'h0, status_reg};
                `CLSS_OFF_POSERR:  o_hrdata <= poserr_reg;
                `CLSS_OFF_MISSED:  o_hrdata <= missed_reg;
                `CLSS_OFF_MKTIME:  o_hrdata <= mktime_reg;
                `CLSS_OFF_ERRCODE: o_hrdata <= {24'h0, errcode_reg};
                default:           o_hrdata <= 32'h00000000;
            endcase
        end
    end
end
wire track = ctrl_reg[`CLSS_CTRL_TRACK];
wire vmode = ctrl_reg[`CLSS_CTRL_VMODE];
wire tmode = ctrl_reg[`CLSS_CTRL_TMODE];
// ****************************************************************
// Calibration, position error and lag/lead tracking.
// ****************************************************************
reg [15:0] cal_cnt_reg;
reg signed [15:0] lag_reg;
reg [LRT_W-1:0] lr_cnt_reg;
reg [15:0] rate_reg;
reg [15:0] phase_reg;
reg        int_step;
reg        int_up;
// The request cycle counts as calibration, so that no step slips through
// in the cycle between enabling tracking and loading the counter.
wire cal    = (cal_cnt_reg != 16'h0000) | cal_req_reg;
// Make-up runs only with an error to recover and the rotor within a full step.
wire mk_act = track & ~cal & ~tmode & ctrl_reg[`CLSS_CTRL_MAKEUP] &
              (poserr_reg != 32'h00000000) & (lag_reg < $signed(`CLSS_FULL_STEP));
// The error counter stops at either end rather than wrapping.
wire pe_sat = (poserr_reg == 32'h7FFFFFFF) | (poserr_reg == 32'h80000000);
// Magnitudes for the limit and full-step compares; pe_big flags errors beyond 16 bits.
wire [15:0] lag_abs = lag_reg[15] ? (16'h0000 - lag_reg) : lag_reg;
wire [15:0] pe_abs  = poserr_reg[31] ? (16'h0000 - poserr_reg[15:0]) : poserr_reg[15:0];
wire pe_big = (poserr_reg[31] ? (poserr_reg[30:15] != 16'hFFFF) : (poserr_reg[30:15] != 16'h0000));
wire cmd_step = step_rise & track & ~cal & ~vmode & ~tmode;
// A host step held back during make-up is a missed step and enters the
// position error; a host step that is passed on is a stator step at once.
wire cmd_held  = cmd_step & mk_act;
wire stat_step = int_step | (cmd_step & ~mk_act);
wire stat_up   = int_step ? int_up : dir_in;
// Tracking and calibration bookkeeping.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        cal_cnt_reg <= `CLSS_CAL_CYCLES;
        poserr_reg  <= 32'h00000000;
        lag_reg     <= 16'sh0000;
        lr_cnt_reg  <= {LRT_W{1'b1}};
        missed_reg  <= 32'h00000000;
        mktime_reg  <= 32'h00000000;
        status_reg  <= 6'h00;
        errcode_reg <= `CLSS_ERR_NONE;
        o_irq       <= 1'b0;
    end else begin
        if (cal_req_reg)
            cal_cnt_reg <= `CLSS_CAL_CYCLES;
        else if (enc_move && cal)
            cal_cnt_reg <= `CLSS_CAL_CYCLES;
        else if (cal)
            cal_cnt_reg <= cal_cnt_reg - 16'h0001;
        if (!track || cal || clr_pos_reg) begin
            poserr_reg <= 32'h00000000;
            lag_reg    <= 16'sh0000;
        end else begin
            // Held host steps add, internal steps taken remove; saturate.
            if (cmd_held && !int_step && !pe_sat) begin
                poserr_reg <= dir_in ? poserr_reg + 32'h1 : poserr_reg - 32'h1;
                missed_reg <= missed_reg + 32'h1;
            end else if (int_step && !cmd_held && !pe_sat) begin
                poserr_reg <= int_up ? poserr_reg - 32'h1 : poserr_reg + 32'h1;
            end
            if (stat_step && !enc_move)
                lag_reg <= stat_up ? lag_reg + 16'sh0001 : lag_reg - 16'sh0001;
            else if (enc_move && !stat_step)
                lag_reg <= enc_up ? lag_reg - 16'sh0001 : lag_reg + 16'sh0001;
        end
        if (mk_act)
            mktime_reg <= mktime_reg + 32'h1;
        // Locked-rotor timer runs at maximum lag and reloads on movement.
        if (enc_move || lag_abs < `CLSS_FULL_STEP || !track)
            lr_cnt_reg <= lrtime_reg;
        else if (lr_cnt_reg != {LRT_W{1'b0}})
            lr_cnt_reg <= lr_cnt_reg - {{(LRT_W-1){1'b0}}, 1'b1};
        // Status bits are live levels; software reads them to find the cause.
        status_reg[`CLSS_ST_TRACK]  <= track & ~cal & (lag_reg != 16'sh0000);
        status_reg[`CLSS_ST_MAKEUP] <= mk_act;
        status_reg[`CLSS_ST_LIMIT]  <= track & (pe_big | pe_abs >= limit_reg);
        status_reg[`CLSS_ST_LOCKED] <= track & (lr_cnt_reg == {LRT_W{1'b0}});
        status_reg[`CLSS_ST_CAL]    <= cal;
        status_reg[`CLSS_ST_OVF]    <= pe_sat;
        // The error code names the most severe condition present.
        if (pe_sat)
            errcode_reg <= `CLSS_ERR_OVF;
        else if (status_reg[`CLSS_ST_LOCKED])
            errcode_reg <= `CLSS_ERR_LOCKED;
        else if (status_reg[`CLSS_ST_LIMIT])
            errcode_reg <= `CLSS_ERR_LIMIT;
        else
            errcode_reg <= `CLSS_ERR_NONE;
        // Registered so that the pin never glitches while the status settles.
        o_irq <= |(status_reg & irqsel_reg);
    end
end
// ****************************************************************
// Internal step generator for velocity, torque and make-up.
// ****************************************************************
// A period below the width limit would outrun the stator stage.
wire [15:0] vel_cap = (vel_reg > maxw_reg) ? vel_reg : maxw_reg;
// Step request decided each cycle from the active mode.
always @* begin
    int_step = 1'b0;
    int_up   = 1'b1;
    if (track && !cal && phase_reg == 16'h0000 && rate_reg != 16'h0000) begin
        if (vmode && rate_reg != 16'h0000) begin
            int_step = 1'b1;
            int_up   = dir_in;
        end else if (tmode && start_in) begin
            int_step = 1'b1;
            int_up   = dir_in;
        end else if (mk_act) begin
            int_step = 1'b1;
            int_up   = ~poserr_reg[31];
        end
    end
end
// Rate is a step period; smaller means faster, never below the width limit.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        rate_reg   <= 16'h0000;
        phase_reg  <= 16'h0000;
    end else begin
        // A stopped generator restarts at once, never from a stale count.
        if (rate_reg == 16'h0000)
            phase_reg <= 16'h0000;
        else if (phase_reg != 16'h0000)
            phase_reg <= phase_reg - 16'h0001;
        else if (int_step)
            phase_reg <= rate_reg;
        if (vmode) begin
            if (!start_in || !track)
                rate_reg <= 16'h0000;
            else if (rate_reg == 16'h0000)
                rate_reg <= 16'hFFFF;
            else if (int_step && rate_reg > vel_cap + accel_reg)
                rate_reg <= rate_reg - accel_reg;
            else if (int_step)
                rate_reg <= vel_cap;
        end else if (tmode) begin
            // Torque mode speeds the stator up until the lead reaches a full step.
            if (!start_in || !track)
                rate_reg <= 16'h0000;
            else if (rate_reg == 16'h0000)
                rate_reg <= 16'hFFFF;
            else if (int_step && lag_abs < `CLSS_FULL_STEP && rate_reg > maxw_reg + accel_reg)
                rate_reg <= rate_reg - accel_reg;
            else if (int_step && lag_abs < `CLSS_FULL_STEP)
                rate_reg <= maxw_reg;
        end else begin
            rate_reg <= maxw_reg;
        end
    end
end
// ****************************************************************
// Output stage.
// ****************************************************************
// Bypass passes the step pin through; tracking drives internal steps.
always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_step      <= 1'b0;
        o_dir       <= 1'b0;
        o_torque_en <= 1'b0;
        o_torque    <= 16'h0000;
    end else if (!track) begin
        o_step      <= step_in;
        o_dir       <= dir_in;
        o_torque_en <= 1'b0;
        o_torque    <= 16'h0000;
    end else begin
        o_step      <= stat_step;
        o_dir       <= stat_up;
        o_torque_en <= tmode & start_in & ~cal;
        o_torque    <= tmode ? vel_reg : 16'h0000;
    end
end
endmodule // clss_supervisor

// ### clss_supervisor_checker.sv
`timescale 1ns/10ps
`include "clss_defs.vh"
// ****************************************************************
// Port checker of the supervisor.
// ****************************************************************
module clss_supervisor_checker (
    input wire        i_ref_clk,
    input wire        i_rst_b,
    input wire        i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0]  i_htrans,
    input wire        i_hwrite,
    input wire [31:0] i_hwdata,
    input wire        i_hready,
    input wire        i_step,
    input wire        o_hreadyout,
    input wire        o_hresp,
    input wire        o_step,
    input wire        o_torque_en,
    input wire [15:0] o_torque,
    input wire        o_irq
);
    reg        wr_reg;
    reg [7:0]  wa_reg;
    reg [5:0]  ctrl_reg;
    reg [5:0]  sel_reg;
    reg [15:0] vel_reg;
    reg [15:0] maxw_reg;
    reg [15:0] gap_reg;
    reg [3:0]  age_reg;
    wire       ctrl_wr = wr_reg && (wa_reg == `CLSS_OFF_CTRL);
    // Shadow copies of written registers, cycles since a control write, and step spacing.
    always @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_reg   <= 1'b0;
            wa_reg   <= 8'h00;
            ctrl_reg <= `CLSS_CTRL_RST;
            sel_reg  <= 6'h00;
            vel_reg  <= 16'h0000;
            maxw_reg <= `CLSS_MAXW_RST;
            gap_reg  <= 16'hFFFF;
            age_reg  <= 4'hF;
        end else begin
            wr_reg  <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
            wa_reg  <= i_haddr[7:0];
            age_reg <= ctrl_wr ? 4'h0 : (age_reg == 4'hF ? age_reg : age_reg + 4'h1);
            gap_reg <= o_step ? 16'h0001 : (gap_reg == 16'hFFFF ? gap_reg : gap_reg + 16'h0001);
            if (ctrl_wr) ctrl_reg <= i_hwdata[5:0];
            if (wr_reg && wa_reg == `CLSS_OFF_IRQSEL) sel_reg <= i_hwdata[5:0];
            if (wr_reg && wa_reg == `CLSS_OFF_VEL) vel_reg <= i_hwdata[15:0];
            if (wr_reg && wa_reg == `CLSS_OFF_MAXW) maxw_reg <= i_hwdata[15:0];
        end
    end
    irq_unselected_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (sel_reg == 6'h00 && $past(sel_reg) == 6'h00) |-> !o_irq) else $error("irq with nothing selected");
    irq_on_cal_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (ctrl_wr && i_hwdata[`CLSS_CTRL_CAL] && sel_reg[`CLSS_ST_CAL]) |-> ##8 o_irq [*8])
        else $error("irq missing during calibration");
    bypass_copy_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (ctrl_reg[2:0] == 3'h0 && age_reg >= 4'h4) |-> o_step == $past(i_step, 3))
        else $error("bypass step not copied");
    step_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (ctrl_reg[0] && o_step) |=> !o_step) else $error("step pulse too long");
    rate_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (o_step && (ctrl_reg[1] || ctrl_reg[2]) && age_reg == 4'hF) |-> gap_reg >= maxw_reg)
        else $error("step rate above maximum");
    cal_mute_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        ($rose(ctrl_reg[0]) && ctrl_reg[2:1] == 2'h0) |-> ##4 !o_step [*8]) else $error("step during calibration");
    torque_mag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_torque_en |-> (o_torque == vel_reg) && ctrl_reg[2]) else $error("torque magnitude wrong");
    torque_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        (!ctrl_reg[2] && age_reg == 4'hF) |-> (o_torque == 16'h0000) && !o_torque_en) else $error("torque outside mode");
    bus_okay_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
        o_hreadyout && !o_hresp) else $error("bus not ready or error");
endmodule // clss_supervisor_checker
bind clss_supervisor clss_supervisor_checker i_clss_supervisor_checker (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata),
    .i_hready(i_hready), .i_step(i_step), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_step(o_step),
    .o_torque_en(o_torque_en), .o_torque(o_torque), .o_irq(o_irq));

// ### clss_supervisor_test.sv
`timescale 1ns/10ps
`include "clss_defs.vh"
// ****************************************************************
// Self-checking bench of the supervisor.
// ****************************************************************
module clss_supervisor_test;
    reg         clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, start = 1'b0, req = 1'b0, follow = 1'b1;
    reg         dir = 1'b1, last = 1'b0;
    reg  [1:0]  htrans = 2'h0;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd, seed = 32'd15362;
    wire [31:0] hrdata;
    wire [15:0] torque;
    wire        hready, hresp, pin, mstep, mdir, enc_a, enc_b, torque_en, irq;
    integer     n_errors = 0, checks_done = 0, nstep = 0, k, k0;
    always #2 clk = ~clk;
    clss_supervisor #(.LRT_W(16)) i_clss_supervisor (.i_ref_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_step(pin),
        .i_dir(dir), .i_start(start), .i_enc_a(enc_a), .i_enc_b(enc_b), .o_step(mstep), .o_dir(mdir),
        .o_torque_en(torque_en), .o_torque(torque), .o_irq(irq));
    clss_far_end i_clss_far_end (.i_ref_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_follow(follow),
        .i_mstep(mstep), .i_mdir(mdir), .o_step_pin(pin), .o_enc_a(enc_a), .o_enc_b(enc_b));
    // Counts rising edges of the step clock output.
    always @(posedge clk) begin
        last <= mstep;
        if (mstep === 1'b1 && last === 1'b0) nstep <= nstep + 1;
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    task tally_and_finish;
        begin
            if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
            end
        end
    endtask
    // One single word transfer; read data is taken at the edge that ends the data phase.
    task bus(input w, input [7:0] a, input [31:0] wd);
        begin
            @(posedge clk);
            hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    // Host steps with random spacing and, in bypass, random direction.
    task steps(input integer n, input rnd_dir);
        begin
            for (k = 0; k < n; k = k + 1) begin
                seed = xs(seed);
                @(posedge clk);
                req <= 1'b1;
                if (rnd_dir) dir <= seed[3];
                @(posedge clk);
                req <= 1'b0;
                repeat (6 + seed[2:0]) @(posedge clk);
            end
        end
    endtask
    initial begin
        #(4 * 40000);
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // Reset values, unmapped place, calibration after reset.
        bus(0, `CLSS_OFF_CTRL, 0); check(rd, 32'h01);
        bus(0, `CLSS_OFF_MAXW, 0); check(rd, 32'h32);
        bus(0, `CLSS_OFF_LIMIT, 0); check(rd, 32'hFFFF);
        bus(0, `CLSS_OFF_LRTIME, 0); check(rd, 32'hFFFF);
        bus(1, 8'h40, 32'hFFFFFFFF); bus(0, 8'h40, 0); check(rd, 32'h0);
        bus(0, `CLSS_OFF_STATUS, 0); check(rd & 32'h10, 32'h10);
        repeat (1100) @(posedge clk);
        bus(0, `CLSS_OFF_STATUS, 0); check(rd & 32'h10, 32'h0);
        // Tracking with a rotor that follows: every host step goes out, none missed.
        bus(1, `CLSS_OFF_MAXW, 8); k0 = nstep; steps(20, 0); repeat (20) @(posedge clk);
        check(nstep - k0, 20);
        bus(0, `CLSS_OFF_MISSED, 0); check(rd, 32'h0);
        bus(0, `CLSS_OFF_MKTIME, 0); check(rd, 32'h0);
        bus(0, `CLSS_OFF_STATUS, 0); check(rd & 32'h0D, 32'h0);
        // Bypass with a still rotor and random direction.
        bus(1, `CLSS_OFF_CTRL, 0); follow <= 1'b0; k0 = nstep; steps(10, 1); repeat (8) @(posedge clk);
        check(nstep - k0, 10);
        check(mdir, dir);
        bus(0, `CLSS_OFF_POSERR, 0); check(rd, 32'h0);
        // Tracking back on with calibration selected as interrupt source; steps are ignored.
        bus(1, `CLSS_OFF_IRQSEL, 32'h10); bus(1, `CLSS_OFF_CTRL, 32'h11); k0 = nstep; steps(5, 0);
        check(nstep - k0, 0);
        check(irq, 1);
        bus(0, `CLSS_OFF_ERRCODE, 0); check(rd, 32'h0);
        bus(1, `CLSS_OFF_IRQSEL, 0); repeat (3) @(posedge clk); check(irq, 0);
        repeat (1100) @(posedge clk);
        // Velocity mode at a random programmed period.
        seed = xs(seed); follow <= 1'b1; dir <= 1'b1;
        bus(1, `CLSS_OFF_VEL, 20 + seed[3:0]); bus(1, `CLSS_OFF_ACCEL, 1); bus(1, `CLSS_OFF_CTRL, 32'h03);
        @(posedge clk); start <= 1'b1; k0 = nstep; repeat (2000) @(posedge clk);
        check(nstep > k0, 1);
        start <= 1'b0; repeat (2000) @(posedge clk); k0 = nstep; repeat (500) @(posedge clk);
        check(nstep - k0, 0);
        // Torque mode against a stalled rotor, make-up enabled but unused.
        follow <= 1'b0; bus(1, `CLSS_OFF_VEL, 32'h0123); bus(1, `CLSS_OFF_MAXW, 16); bus(1, `CLSS_OFF_LIMIT, 1);
        bus(1, `CLSS_OFF_CTRL, 32'h2D); @(posedge clk); start <= 1'b1; k0 = nstep; repeat (20) @(posedge clk);
        check(torque_en, 1);
        check(torque, 16'h0123);
        repeat (2000) @(posedge clk);
        check(nstep > k0, 1);
        bus(0, `CLSS_OFF_STATUS, 0); check(rd & 32'h02, 32'h0);
        check(rd & 32'h04, 32'h04);
        bus(0, `CLSS_OFF_ERRCODE, 0); check(rd, 32'h1);
        bus(0, `CLSS_OFF_POSERR, 0); check(rd != 32'h0, 1);
        start <= 1'b0; repeat (20) @(posedge clk);
        check(torque_en, 0);
        tally_and_finish;
    end
endmodule // clss_supervisor_test
